// ### inc/dbsp_pkg.sv
// Purpose: shared constants and types for the burst sram port
// Assumes: one beat per clk_sys_i edge; beats alternate positive/negative clock rise
// Notes: wide (four lane) data width

package dbsp_pkg;
   // =====================================================================
   // widths and geometry
   // =====================================================================
   localparam int DATA_W = 36;
   localparam int LANE_W = 9;
   localparam int LANES = 4;
   localparam int ADDR_W = 8;
   localparam int DEPTH = 256;
   localparam int BURST_LEN = 4;
   localparam int FIFO_DEPTH = 8;
   localparam logic [2:0] BURST_LEN_C = 3'h4;

   // =====================================================================
   // beat timing, counted in edges after the launching positive rise
   // =====================================================================
   localparam int LAUNCH_SH_W = 8;
   localparam int WR_FIRST_TAP = 1;
   localparam int RD_POP_TAP_SLOW = 4;
   localparam int RD_POP_TAP_FAST = 1;
   localparam int RD_VLD_TAP_SLOW = 3;
   localparam int RD_VLD_TAP_FAST = 0;

   // =====================================================================
   // reset values
   // =====================================================================
   localparam logic K_PHASE_RST = 1'b1;
   localparam logic OE_N_RST = 1'b1;

   typedef logic [ADDR_W-1:0] dbsp_addr_t;
   typedef logic [DATA_W-1:0] dbsp_data_t;
   typedef logic [LANES-1:0] dbsp_lane_t;

   typedef struct packed {
      dbsp_data_t data;
      dbsp_lane_t lane_sel_n;
   } dbsp_beat_s;
endpackage : dbsp_pkg

// ### logic/dbsp_fifo.sv
// Purpose: parameterised fifo with valid/ready on both sides
// Assumes: single clock, synchronous active high reset
// Notes: out_data_o is the head word, valid while out_valid_o is high
`timescale 1ns/1ns

module dbsp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
   localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

   logic [WIDTH-1:0] store_ff [DEPTH];
   logic [PTR_W-1:0] wr_ptr_ff;
   logic [PTR_W-1:0] rd_ptr_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic push;
   logic pop;

   assign in_ready_o = (cnt_ff != FULL_CNT);
   assign out_valid_o = (cnt_ff != '0);
   assign out_data_o = store_ff[rd_ptr_ff];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         store_ff[wr_ptr_ff] <= in_data_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + 1'b1;
         end
         if (push && !pop) begin
            cnt_ff <= cnt_ff + 1'b1;
         end else if (pop && !push) begin
            cnt_ff <= cnt_ff - 1'b1;
         end
      end
   end
endmodule : dbsp_fifo

// ### logic/dbsp_port.sv
// Purpose: double-data-rate burst sram port with separate read and write data
// Assumes: each clk_sys_i edge is one beat; the first edge after reset is a positive rise;
//          controller inputs come from logic on the same clock
// Notes: read words pass through an 8 word fifo between array and output register
//
// Contract
// - write select low latches address, data follows
// - write beats A..A+3 on edges two to five
// - read select low latches address, long latency
// - read words A..A+3 on edges five to eight, or two to five while pll_disable_n_i is low
// - burst covers A, A+1, A+2, A+3
// - write data taken on every beat edge
// - read data launched on every beat edge
// - after reset deselected, outputs high impedance
// - back-to-back same-type request is discarded
// - select used last cycle is ignored now
// - beats counted from launching positive rise
// - lane selects gate nine-bit lanes per beat
// - all selects high leaves word unchanged
// - four selects gate lanes low to high
// - all four high on beat writes nothing
// - both selected from idle, read first
// - read after write sees newest data
// - valid indicator rises half cycle early
`timescale 1ns/1ns

module dbsp_port
   import dbsp_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic read_port_select_n_i,
   input wire logic write_port_select_n_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wr_data_i,
   input wire logic [LANES-1:0] byte_lane_write_select_n_i,
   input wire logic pll_disable_n_i,
   output logic [DATA_W-1:0] rd_data_o,
   output logic rd_data_oe_n_o,
   output logic read_valid_indicator_o,
   output logic k_phase_o
);
   // =====================================================================
   // functions
   // =====================================================================
   function automatic dbsp_addr_t burst_addr(input dbsp_addr_t base, input logic [1:0] idx);
      burst_addr = base + ADDR_W'(idx);
   endfunction : burst_addr

   function automatic dbsp_data_t lane_merge(input dbsp_data_t old_w, input dbsp_beat_s bt);
      dbsp_data_t res;
      res = old_w;
      for (int i = 0; i < LANES; i++) begin
         if (!bt.lane_sel_n[i]) begin
            res[i*LANE_W +: LANE_W] = bt.data[i*LANE_W +: LANE_W];
         end
      end
      lane_merge = res;
   endfunction : lane_merge

   // =====================================================================
   // beat phase and request arbitration
   // =====================================================================
   logic k_phase_ff;
   logic prev_rd_ff;
   logic prev_wr_ff;
   logic rd_req;
   logic wr_req;
   logic launch_rd;
   logic launch_wr;

   // edge with k_phase_ff high is the launching positive rise
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         k_phase_ff <= K_PHASE_RST;
      end else begin
         k_phase_ff <= !k_phase_ff;
      end
   end

   assign rd_req = k_phase_ff && !read_port_select_n_i && !prev_rd_ff;
   assign wr_req = k_phase_ff && !write_port_select_n_i && !prev_wr_ff;
   assign launch_rd = rd_req;
   assign launch_wr = wr_req && !rd_req;

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         prev_rd_ff <= 1'b0;
         prev_wr_ff <= 1'b0;
      end else if (k_phase_ff) begin
         prev_rd_ff <= launch_rd;
         prev_wr_ff <= launch_wr;
      end
   end

   // =====================================================================
   // memory array and write beats
   // =====================================================================
   dbsp_data_t mem_ff [DEPTH];
   dbsp_addr_t wr_addr_ff;
   logic [LAUNCH_SH_W-1:0] wr_sh_ff;
   logic [LAUNCH_SH_W-1:0] rd_sh_ff;
   logic [1:0] wr_beat;
   logic wr_beat_en;
   dbsp_beat_s wr_beat_in;
   dbsp_addr_t wr_beat_addr;

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         wr_sh_ff <= '0;
         rd_sh_ff <= '0;
      end else begin
         wr_sh_ff <= {wr_sh_ff[LAUNCH_SH_W-2:0], launch_wr};
         rd_sh_ff <= {rd_sh_ff[LAUNCH_SH_W-2:0], launch_rd};
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         wr_addr_ff <= '0;
      end else if (launch_wr) begin
         wr_addr_ff <= addr_i;
      end
   end

   always_comb begin
      wr_beat = 2'h0;
      for (int i = 0; i < BURST_LEN; i++) begin
         if (wr_sh_ff[WR_FIRST_TAP + i]) begin
            wr_beat = 2'(i);
         end
      end
   end

   assign wr_beat_en = |wr_sh_ff[WR_FIRST_TAP +: BURST_LEN];
   assign wr_beat_in = '{data: wr_data_i, lane_sel_n: byte_lane_write_select_n_i};
   assign wr_beat_addr = burst_addr(wr_addr_ff, wr_beat);

   // writes land in the array at once, so later fetches see them
   always_ff @(posedge clk_sys_i) begin
      if (wr_beat_en) begin
         mem_ff[wr_beat_addr] <= lane_merge(mem_ff[wr_beat_addr], wr_beat_in);
      end
   end

   // =====================================================================
   // read fetch into fifo
   // =====================================================================
   dbsp_addr_t rd_addr_ff;
   logic [2:0] fetch_left_ff;
   logic [1:0] fetch_idx_ff;
   logic fetch_valid;
   logic fetch_ready;
   logic head_valid;
   dbsp_data_t head_data;
   logic pop_en;

   assign fetch_valid = (fetch_left_ff != '0);

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         rd_addr_ff <= '0;
         fetch_left_ff <= '0;
         fetch_idx_ff <= '0;
      end else if (launch_rd) begin
         rd_addr_ff <= addr_i;
         fetch_left_ff <= BURST_LEN_C;
         fetch_idx_ff <= '0;
      end else if (fetch_valid && fetch_ready) begin
         fetch_left_ff <= fetch_left_ff - 1'b1;
         fetch_idx_ff <= fetch_idx_ff + 1'b1;
      end
   end

   dbsp_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_rd_fifo (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .in_valid_i(fetch_valid),
      .in_ready_o(fetch_ready),
      .in_data_i(mem_ff[burst_addr(rd_addr_ff, fetch_idx_ff)]),
      .out_valid_o(head_valid),
      .out_ready_i(pop_en),
      .out_data_o(head_data)
   );

   // =====================================================================
   // output schedule
   // =====================================================================
   logic [LAUNCH_SH_W:0] rd_taps;
   logic pop_win;
   logic vld_win;

   assign rd_taps = {rd_sh_ff, launch_rd};

   always_comb begin
      if (pll_disable_n_i) begin
         pop_win = |rd_taps[RD_POP_TAP_SLOW + 1 +: BURST_LEN];
         vld_win = |rd_taps[RD_VLD_TAP_SLOW + 1 +: BURST_LEN];
      end else begin
         pop_win = |rd_taps[RD_POP_TAP_FAST + 1 +: BURST_LEN];
         vld_win = |rd_taps[RD_VLD_TAP_FAST + 1 +: BURST_LEN];
      end
   end

   assign pop_en = pop_win && head_valid;

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         rd_data_o <= '0;
         rd_data_oe_n_o <= OE_N_RST;
         read_valid_indicator_o <= 1'b0;
      end else begin
         if (pop_en) begin
            rd_data_o <= head_data;
         end
         rd_data_oe_n_o <= !pop_en;
         read_valid_indicator_o <= vld_win;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         k_phase_o <= K_PHASE_RST;
      end else begin
         k_phase_o <= !k_phase_ff;
      end
   end
endmodule : dbsp_port

// ### testbench/dbsp_port_chk.sv
// Purpose: timing checker for dbsp_port
// Assumes: bound to every dbsp_port
// Notes: rd_prev_ff tracks read acceptance on positive rises
`timescale 1ns/1ns
module dbsp_port_chk
   import dbsp_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic read_port_select_n_i,
   input wire logic pll_disable_n_i,
   input wire logic [DATA_W-1:0] rd_data_o,
   input wire logic rd_data_oe_n_o,
   input wire logic read_valid_indicator_o,
   input wire logic k_phase_o
);
   logic rd_prev_ff;
   logic acc;
   assign acc = k_phase_o && !read_port_select_n_i && !rd_prev_ff;
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         rd_prev_ff <= 1'b0;
      end else if (k_phase_o) begin
         rd_prev_ff <= acc;
      end
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   // =====
   // assertions
   property p_rst; $fell(srst_i) |-> rd_data_oe_n_o && !read_valid_indicator_o; endproperty
   a_rst: assert property (p_rst) else $error("outputs live after reset");
   property p_slow; acc && pll_disable_n_i |-> ##5 read_valid_indicator_o
      ##1 !rd_data_oe_n_o; endproperty
   a_slow: assert property (p_slow) else $error("slow read timing wrong");
   property p_fast; acc && !pll_disable_n_i |-> ##2 read_valid_indicator_o
      ##1 !rd_data_oe_n_o; endproperty
   a_fast: assert property (p_fast) else $error("fast read timing wrong");
   property p_four; $fell(rd_data_oe_n_o) |-> !rd_data_oe_n_o [*4]; endproperty
   a_four: assert property (p_four) else $error("burst shorter than four");
   property p_lead; $rose(read_valid_indicator_o) |-> rd_data_oe_n_o ##1 !rd_data_oe_n_o;
   endproperty
   a_lead: assert property (p_lead) else $error("valid not one beat early");
   property p_cause; $fell(rd_data_oe_n_o) |-> $past(read_valid_indicator_o); endproperty
   a_cause: assert property (p_cause) else $error("drive without valid");
   property p_end; !rd_data_oe_n_o && !read_valid_indicator_o |=> rd_data_oe_n_o;
   endproperty
   a_end: assert property (p_end) else $error("output not released");
   property p_hold; rd_data_oe_n_o && $past(rd_data_oe_n_o) |-> $stable(rd_data_o);
   endproperty
   a_hold: assert property (p_hold) else $error("idle data moved");
   property p_phase; !$past(srst_i) |-> k_phase_o != $past(k_phase_o); endproperty
   a_phase: assert property (p_phase) else $error("phase not alternating");
endmodule : dbsp_port_chk

bind dbsp_port dbsp_port_chk u_chk (.clk_sys_i, .srst_i, .read_port_select_n_i,
   .pll_disable_n_i, .rd_data_o, .rd_data_oe_n_o, .read_valid_indicator_o, .k_phase_o);

// ### testbench/dbsp_ctrl_model.sv
// Purpose: memory controller model driving the port
// Assumes: k_phase_i high means the next edge is a positive rise
// Notes: write beats follow each accepted write by themselves
`timescale 1ns/1ns
module dbsp_ctrl_model
   import dbsp_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic k_phase_i,
   output logic rd_sel_n_o,
   output logic wr_sel_n_o,
   output logic [ADDR_W-1:0] addr_o,
   output logic [DATA_W-1:0] data_o,
   output logic [LANES-1:0] lane_n_o
);
   dbsp_beat_s beat [BURST_LEN];
   int idx = 5;
   int ec = 0;
   int rd_at = 0;
   int stuck = 0;
   logic rd_prev = 1'b0;
   logic wr_prev = 1'b0;
   logic ra;
   logic wa;
   initial begin
      rd_sel_n_o = 1'b1;
      wr_sel_n_o = 1'b1;
      addr_o = '0;
      data_o = '0;
      lane_n_o = '1;
   end
   // =====
   // beats, and lines flipped once a burst is over
   always @(posedge clk_sys_i) begin
      ec++;
      if (idx < 4) begin
         data_o <= beat[idx].data;
         lane_n_o <= beat[idx].lane_sel_n;
      end else if (idx == 4) begin
         data_o <= ~data_o;
         lane_n_o <= ~lane_n_o;
      end
      idx++;
      if (srst_i) begin
         rd_prev = 1'b0;
         wr_prev = 1'b0;
      end else if (k_phase_i) begin
         ra = !rd_sel_n_o && !rd_prev;
         wa = !wr_sel_n_o && !wr_prev && !ra;
         rd_prev = ra;
         wr_prev = wa;
         if (ra) rd_at = ec;
         if (wa) idx = 0;
      end
   end
   task automatic op(input logic rd, input logic wr, input dbsp_addr_t a, input int n);
      int k;
      k = 0;
      do begin
         @(posedge clk_sys_i);
         k++;
      end while (k_phase_i !== 1'b0 && k < 4);
      if (k_phase_i !== 1'b0) stuck++;
      rd_sel_n_o <= !rd;
      wr_sel_n_o <= !wr;
      addr_o <= a;
      repeat (2 * n) @(posedge clk_sys_i);
      rd_sel_n_o <= 1'b1;
      wr_sel_n_o <= 1'b1;
      addr_o <= ~a;
   endtask : op
   // write on one positive rise, read of the same base on the next one
   task automatic wr_rd(input dbsp_addr_t a);
      int k;
      k = 0;
      do begin
         @(posedge clk_sys_i);
         k++;
      end while (k_phase_i !== 1'b0 && k < 4);
      if (k_phase_i !== 1'b0) stuck++;
      wr_sel_n_o <= 1'b0;
      addr_o <= a;
      repeat (2) @(posedge clk_sys_i);
      wr_sel_n_o <= 1'b1;
      rd_sel_n_o <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      rd_sel_n_o <= 1'b1;
      addr_o <= ~a;
   endtask : wr_rd
endmodule : dbsp_ctrl_model

// ### testbench/dbsp_port_tb.sv
// Purpose: self-checking bench for dbsp_port
// Assumes: controller model owns the request pins
// Notes: read words are captured at the falling clock edge
`timescale 1ns/1ns
module dbsp_port_tb
   import dbsp_pkg::*;
;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic pll_n = 1'b1;
   logic run = 1'b1;
   logic rsel_n, wsel_n, kph, oe_n, vld;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wd, rd;
   logic [LANES-1:0] lane_n;
   dbsp_data_t mem [DEPTH];
   dbsp_data_t q [$];
   int lat [$];
   int fails = 0;
   int checks = 0;
   // clock parks high while run is low
   always #2 if (run || !clk) clk = ~clk;
   dbsp_port DUT (.clk_sys_i(clk), .srst_i(srst), .read_port_select_n_i(rsel_n),
      .write_port_select_n_i(wsel_n), .addr_i(addr), .wr_data_i(wd),
      .byte_lane_write_select_n_i(lane_n), .pll_disable_n_i(pll_n), .rd_data_o(rd),
      .rd_data_oe_n_o(oe_n), .read_valid_indicator_o(vld), .k_phase_o(kph));
   dbsp_ctrl_model ctl (.clk_sys_i(clk), .srst_i(srst), .k_phase_i(kph),
      .rd_sel_n_o(rsel_n), .wr_sel_n_o(wsel_n), .addr_o(addr), .data_o(wd), .lane_n_o(lane_n));
   always @(negedge clk) begin
      if (oe_n === 1'b0) begin
         q.push_back(rd);
         lat.push_back(ctl.ec - ctl.rd_at);
      end
   end
   // =====
   // shared tasks
   task conclude();
      if (fails == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : conclude
   task chk(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input dbsp_addr_t a, input dbsp_data_t d, input logic [15:0] m);
      for (int i = 0; i < BURST_LEN; i++) ctl.beat[i] = '{d ^ {LANES{9'(i + 1)}}, m[4*i+:4]};
      q.delete();
      lat.delete();
      ctl.op(1'b0, 1'b1, a, 1);
   endtask : wr
   task automatic put(input dbsp_addr_t a);
      for (int i = 0; i < BURST_LEN; i++)
         for (int l = 0; l < LANES; l++)
            if (!ctl.beat[i].lane_sel_n[l])
               mem[a + 8'(i)][LANE_W*l+:LANE_W] = ctl.beat[i].data[LANE_W*l+:LANE_W];
   endtask : put
   task automatic grab(input dbsp_addr_t a, input int lt);
      for (int k = 0; k < 40 && q.size() < 4; k++) @(posedge clk);
      repeat (12) @(posedge clk);
      chk(q.size(), 4);
      if (q.size() < 4) conclude();
      chk(lat[0], lt);
      for (int i = 0; i < 4; i++) chk(q[i], mem[a + 8'(i)]);
   endtask : grab
   task automatic rd_chk(input dbsp_addr_t a, input int lt);
      q.delete();
      lat.delete();
      ctl.op(1'b1, 1'b0, a, 1);
      grab(a, lt);
   endtask : rd_chk
   // =====
   // scenarios
   task t_burst();
      wr(8'hfe, 36'h123456789, 16'h0000);
      put(8'hfe);
      rd_chk(8'hfe, 5);
   endtask : t_burst
   task t_mask();
      wr(8'hfe, 36'hfedcba987, 16'h0f5e);
      put(8'hfe);
      rd_chk(8'hfe, 5);
   endtask : t_mask
   task t_fast();
      @(posedge clk) pll_n <= 1'b0;
      rd_chk(8'hfe, 2);
      @(posedge clk) pll_n <= 1'b1;
   endtask : t_fast
   task t_both();
      for (int i = 0; i < BURST_LEN; i++)
         ctl.beat[i] = '{36'h0a5a5a5a5 ^ {LANES{9'(i + 1)}}, 4'h0};
      q.delete();
      lat.delete();
      ctl.op(1'b1, 1'b1, 8'hfe, 2);
      grab(8'hfe, 5);
      put(8'hfe);
      rd_chk(8'hfe, 5);
   endtask : t_both
   task t_fwd();
      for (int i = 0; i < BURST_LEN; i++)
         ctl.beat[i] = '{36'h2468ace13 ^ {LANES{9'(i + 5)}}, 4'h0};
      q.delete();
      lat.delete();
      ctl.wr_rd(8'h7f);
      put(8'h7f);
      grab(8'h7f, 5);
   endtask : t_fwd
   task t_stop();
      q.delete();
      lat.delete();
      ctl.op(1'b1, 1'b0, 8'hfe, 1);
      run = 1'b0;
      #40;
      run = 1'b1;
      grab(8'hfe, 5);
   endtask : t_stop
   initial begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      @(negedge clk);
      chk(oe_n, 1);
      chk(vld, 0);
      chk(rd, 0);
      t_burst();
      t_mask();
      t_fast();
      ctl.beat[0].data = '0;
      t_both();
      t_fwd();
      t_stop();
      chk(ctl.stuck, 0);
      conclude();
   end
endmodule : dbsp_port_tb
